/* File: pkg/rac_pkg.sv */
// package: attribute codes and reset constants for the register attribute cells
package rac_pkg;
   // =====================================================================
   // access attributes
   // =====================================================================
   typedef enum logic [3:0] {
      ATTR_READ_ONLY,
      ATTR_READ_WRITE,
      ATTR_SET_ON_READ_CLEAR_BY_ONE,
      ATTR_EVENT_SET_CLEAR_BY_ONE,
      ATTR_STICKY_EVENT_CLEAR_BY_ONE,
      ATTR_STICKY_READ_WRITE,
      ATTR_LOCKABLE_READ_WRITE,
      ATTR_SELF_CLEARING,
      ATTR_LOCKABLE_SELF_CLEARING,
      ATTR_WRITE_ONCE,
      ATTR_WRITE_ONLY
   } rac_attr_t;

   // =====================================================================
   // reset values and sizes
   // =====================================================================
   localparam int          RAC_DEF_WIDTH = 32;
   localparam logic [31:0] RAC_RST_VAL   = 32'h00000000;
   localparam logic        RAC_BIT_ZERO  = 1'h0;
   localparam logic        RAC_BIT_ONE   = 1'h1;
endpackage : rac_pkg

/* File: rtl/rac_bit_cell.sv */
// one register bit cell with a selectable access attribute
`timescale 1ns/1ps
module rac_bit_cell
   import rac_pkg::*;
#(
   parameter rac_attr_t ATTR    = ATTR_READ_WRITE,
   parameter logic      RST_VAL = RAC_BIT_ZERO
) (
   input  wire logic mclk,
   input  wire logic warmRst,
   input  wire logic coldRst,
   input  wire logic wrEn,
   input  wire logic wrBit,
   input  wire logic rdEn,
   input  wire logic hwSet,
   input  wire logic hwClr,
   input  wire logic hwVal,
   input  wire logic lockBit,
   output logic      rdBit,
   output logic      storeBit,
   output logic      wrPulse
);
   // ======================================================================
   // next state
   // ======================================================================
   logic bit_ff;
   logic nxt_bit;
   logic written_ff;
   logic nxt_written;
   logic pulse_ff;
   logic nxt_pulse;
   logic sticky;

   assign sticky = (ATTR == ATTR_STICKY_EVENT_CLEAR_BY_ONE) || (ATTR == ATTR_STICKY_READ_WRITE);

   always_comb begin
      nxt_bit     = bit_ff;
      nxt_written = written_ff;
      nxt_pulse   = RAC_BIT_ZERO;
      case (ATTR)
         ATTR_READ_ONLY: begin
            nxt_bit = hwVal;
         end
         ATTR_READ_WRITE, ATTR_STICKY_READ_WRITE: begin
            if (wrEn) begin
               nxt_bit = wrBit;
            end
         end
         ATTR_LOCKABLE_READ_WRITE: begin
            if (wrEn && !lockBit) begin
               nxt_bit = wrBit;
            end
         end
         ATTR_SET_ON_READ_CLEAR_BY_ONE: begin
            if (wrEn && wrBit) begin
               nxt_bit = RAC_BIT_ZERO;
            end else if (rdEn) begin
               nxt_bit = RAC_BIT_ONE;
            end
         end
         ATTR_EVENT_SET_CLEAR_BY_ONE, ATTR_STICKY_EVENT_CLEAR_BY_ONE: begin
            // set wins so an event in the clearing cycle is kept
            if (hwSet) begin
               nxt_bit = RAC_BIT_ONE;
            end else if (wrEn && wrBit) begin
               nxt_bit = RAC_BIT_ZERO;
            end
         end
         ATTR_SELF_CLEARING, ATTR_LOCKABLE_SELF_CLEARING: begin
            if (wrEn && !(ATTR == ATTR_LOCKABLE_SELF_CLEARING && lockBit)) begin
               nxt_bit = wrBit;
            end else if (hwClr) begin
               nxt_bit = RAC_BIT_ZERO;
            end
         end
         ATTR_WRITE_ONCE: begin
            if (wrEn && !written_ff) begin
               nxt_bit     = wrBit;
               nxt_written = RAC_BIT_ONE;
            end
         end
         ATTR_WRITE_ONLY: begin
            nxt_bit   = RAC_BIT_ZERO;
            nxt_pulse = wrEn && wrBit;
         end
         default: begin
            nxt_bit = bit_ff;
         end
      endcase
   end

   // ======================================================================
   // registers
   // ======================================================================
   always_ff @(posedge mclk) begin
      // sticky cells ignore the warm reset
      if (coldRst || (warmRst && !sticky)) begin
         bit_ff     <= RST_VAL;
         written_ff <= RAC_BIT_ZERO;
         pulse_ff   <= RAC_BIT_ZERO;
      end else begin
         bit_ff     <= nxt_bit;
         written_ff <= nxt_written;
         pulse_ff   <= nxt_pulse;
      end
   end

   assign rdBit    = (ATTR == ATTR_WRITE_ONLY) ? RAC_BIT_ZERO : bit_ff;
   assign storeBit = bit_ff;
   assign wrPulse  = pulse_ff;
endmodule : rac_bit_cell

/* File: rtl/rac_attr_bank.sv */
// bank of attribute cells behind a generic read/write port
//
// Operation
// - read-only bits ignore writes and show the hardware value.
// - read-write bits return last write, or reset value.
// - set-on-read bits become one when read, stay until written.
// - set-on-read bits clear on written one; written zero does nothing.
// - event bits set by hardware; written one clears, zero ignored.
// - clear-by-one bits: written one clears, written zero keeps value.
// - sticky event bits behave as event bits and survive warm reset.
// - sticky read-write bits are read-write and survive warm reset.
// - sticky bits are reset only by cold reset.
// - lockable fields take writes only while lock bit clear.
// - self-clearing bits are writable; hardware may clear them.
// - lockable self-clearing bits ignore writes while locked.
// - write-once bits take the first write after reset only.
// - written write-once bits clear only on reset.
// - write-only bits always read as zero.
// - write-only bits give a side effect and keep nothing.
`timescale 1ns/1ps
module rac_attr_bank
   import rac_pkg::*;
#(
   parameter int WIDTH = RAC_DEF_WIDTH
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic             coldRst,
   input  wire logic             rdEn,
   input  wire logic             wrEn,
   input  wire logic [3:0]       attrSel,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic [WIDTH-1:0] hwSet,
   input  wire logic [WIDTH-1:0] hwClr,
   input  wire logic [WIDTH-1:0] hwVal,
   output logic      [WIDTH-1:0] rdData,
   output logic                  rdValid,
   output logic      [WIDTH-1:0] fieldVal,
   output logic      [WIDTH-1:0] wrPulse
);
   // ======================================================================
   // parameter check
   // ======================================================================
   // word count follows the attribute list, so a new attribute adds a word to the bank
   localparam int NUM_ATTR  = int'(ATTR_WRITE_ONLY) + 1;
   localparam int MAX_WIDTH = $bits(RAC_RST_VAL);
   localparam int SEL_SPAN  = 1 << $bits(attrSel);

   // reset values come from one package word, so a wider bank has none to take
   if (WIDTH < 1 || WIDTH > MAX_WIDTH) begin : gBadWidth
      $error("rac_attr_bank: WIDTH out of range");
   end

   // a select too narrow would leave the top words unreachable
   if (NUM_ATTR > SEL_SPAN) begin : gBadSel
      $error("rac_attr_bank: attribute select cannot reach every word");
   end

   // ======================================================================
   // word decode: one write and one read strobe per attribute word
   // ======================================================================
   logic [NUM_ATTR-1:0] wrHit;
   logic [NUM_ATTR-1:0] rdHit;
   logic                selOk;

   // codes past the last word hit nothing, so stray writes are dropped and stray reads return zero
   always_comb begin
      wrHit = '0;
      rdHit = '0;
      selOk = RAC_BIT_ZERO;
      case (attrSel)
         ATTR_READ_ONLY: begin
            wrHit[ATTR_READ_ONLY] = wrEn;
            rdHit[ATTR_READ_ONLY] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_READ_WRITE: begin
            wrHit[ATTR_READ_WRITE] = wrEn;
            rdHit[ATTR_READ_WRITE] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_SET_ON_READ_CLEAR_BY_ONE: begin
            wrHit[ATTR_SET_ON_READ_CLEAR_BY_ONE] = wrEn;
            rdHit[ATTR_SET_ON_READ_CLEAR_BY_ONE] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_EVENT_SET_CLEAR_BY_ONE: begin
            wrHit[ATTR_EVENT_SET_CLEAR_BY_ONE] = wrEn;
            rdHit[ATTR_EVENT_SET_CLEAR_BY_ONE] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_STICKY_EVENT_CLEAR_BY_ONE: begin
            wrHit[ATTR_STICKY_EVENT_CLEAR_BY_ONE] = wrEn;
            rdHit[ATTR_STICKY_EVENT_CLEAR_BY_ONE] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_STICKY_READ_WRITE: begin
            wrHit[ATTR_STICKY_READ_WRITE] = wrEn;
            rdHit[ATTR_STICKY_READ_WRITE] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_LOCKABLE_READ_WRITE: begin
            wrHit[ATTR_LOCKABLE_READ_WRITE] = wrEn;
            rdHit[ATTR_LOCKABLE_READ_WRITE] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_SELF_CLEARING: begin
            wrHit[ATTR_SELF_CLEARING] = wrEn;
            rdHit[ATTR_SELF_CLEARING] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_LOCKABLE_SELF_CLEARING: begin
            wrHit[ATTR_LOCKABLE_SELF_CLEARING] = wrEn;
            rdHit[ATTR_LOCKABLE_SELF_CLEARING] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_WRITE_ONCE: begin
            wrHit[ATTR_WRITE_ONCE] = wrEn;
            rdHit[ATTR_WRITE_ONCE] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         ATTR_WRITE_ONLY: begin
            wrHit[ATTR_WRITE_ONLY] = wrEn;
            rdHit[ATTR_WRITE_ONLY] = rdEn;
            selOk = RAC_BIT_ONE;
         end
         default: begin
            wrHit = '0;
            rdHit = '0;
            selOk = RAC_BIT_ZERO;
         end
      endcase
   end

   // ======================================================================
   // lock bit: the lockable read-write word top bit (WIDTH-1) guards both lockable words
   // ======================================================================
   logic [WIDTH-1:0] cellRd    [NUM_ATTR];
   logic [WIDTH-1:0] cellStore [NUM_ATTR];
   logic [WIDTH-1:0] cellPulse [NUM_ATTR];
   logic             lockBit;
   logic             lock_ff;
   logic             nxt_lock;
   logic             lockWrite;

   // the lock only ever arms; a reset is the one way to open it again
   always_comb begin
      lockWrite = wrHit[ATTR_LOCKABLE_READ_WRITE] && wrData[WIDTH-1];
      nxt_lock  = lock_ff;
      if (lockWrite) begin
         nxt_lock = RAC_BIT_ONE;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || coldRst) begin
         lock_ff <= RAC_BIT_ZERO;
      end else begin
         lock_ff <= nxt_lock;
      end
   end

   assign lockBit = lock_ff;

   // ======================================================================
   // cells, one word per attribute
   // ======================================================================
   // one cell per bit; repeating the cell keeps every attribute in one place
   for (genvar a = 0; a < NUM_ATTR; a++) begin : gAttr
      for (genvar b = 0; b < WIDTH; b++) begin : gBit
         rac_bit_cell #(
            .ATTR    (rac_attr_t'(a)),
            .RST_VAL (RAC_RST_VAL[b])
         ) uCell (
            .mclk     (mclk),
            .warmRst  (sys_rst),
            .coldRst  (coldRst),
            .wrEn     (wrHit[a]),
            .wrBit    (wrData[b]),
            .rdEn     (rdHit[a]),
            .hwSet    (hwSet[b]),
            .hwClr    (hwClr[b]),
            .hwVal    (hwVal[b]),
            .lockBit  (lockBit),
            .rdBit    (cellRd[a][b]),
            .storeBit (cellStore[a][b]),
            .wrPulse  (cellPulse[a][b])
         );
      end
   end

   // ======================================================================
   // read port and outputs, all registered
   // ======================================================================
   logic [WIDTH-1:0] rdData_ff;
   logic [WIDTH-1:0] nxt_rdData;
   logic             rdValid_ff;
   logic             nxt_rdValid;
   logic [WIDTH-1:0] field_ff;
   logic [WIDTH-1:0] nxt_field;
   logic [WIDTH-1:0] rdWord;
   logic [WIDTH-1:0] stWord;

   // word select shared by the read data and the field view
   always_comb begin
      rdWord = '0;
      stWord = '0;
      case (attrSel)
         ATTR_READ_ONLY: begin
            rdWord = cellRd[ATTR_READ_ONLY];
            stWord = cellStore[ATTR_READ_ONLY];
         end
         ATTR_READ_WRITE: begin
            rdWord = cellRd[ATTR_READ_WRITE];
            stWord = cellStore[ATTR_READ_WRITE];
         end
         ATTR_SET_ON_READ_CLEAR_BY_ONE: begin
            rdWord = cellRd[ATTR_SET_ON_READ_CLEAR_BY_ONE];
            stWord = cellStore[ATTR_SET_ON_READ_CLEAR_BY_ONE];
         end
         ATTR_EVENT_SET_CLEAR_BY_ONE: begin
            rdWord = cellRd[ATTR_EVENT_SET_CLEAR_BY_ONE];
            stWord = cellStore[ATTR_EVENT_SET_CLEAR_BY_ONE];
         end
         ATTR_STICKY_EVENT_CLEAR_BY_ONE: begin
            rdWord = cellRd[ATTR_STICKY_EVENT_CLEAR_BY_ONE];
            stWord = cellStore[ATTR_STICKY_EVENT_CLEAR_BY_ONE];
         end
         ATTR_STICKY_READ_WRITE: begin
            rdWord = cellRd[ATTR_STICKY_READ_WRITE];
            stWord = cellStore[ATTR_STICKY_READ_WRITE];
         end
         ATTR_LOCKABLE_READ_WRITE: begin
            rdWord = cellRd[ATTR_LOCKABLE_READ_WRITE];
            stWord = cellStore[ATTR_LOCKABLE_READ_WRITE];
         end
         ATTR_SELF_CLEARING: begin
            rdWord = cellRd[ATTR_SELF_CLEARING];
            stWord = cellStore[ATTR_SELF_CLEARING];
         end
         ATTR_LOCKABLE_SELF_CLEARING: begin
            rdWord = cellRd[ATTR_LOCKABLE_SELF_CLEARING];
            stWord = cellStore[ATTR_LOCKABLE_SELF_CLEARING];
         end
         ATTR_WRITE_ONCE: begin
            rdWord = cellRd[ATTR_WRITE_ONCE];
            stWord = cellStore[ATTR_WRITE_ONCE];
         end
         ATTR_WRITE_ONLY: begin
            rdWord = cellRd[ATTR_WRITE_ONLY];
            stWord = cellStore[ATTR_WRITE_ONLY];
         end
         default: begin
            rdWord = '0;
            stWord = '0;
         end
      endcase
   end

   // read returns the value before any read side effect lands
   always_comb begin
      nxt_rdData  = rdData_ff;
      nxt_rdValid = rdEn;
      if (rdEn && selOk) begin
         nxt_rdData = rdWord;
      end else if (rdEn) begin
         nxt_rdData = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || coldRst) begin
         rdData_ff  <= '0;
         rdValid_ff <= RAC_BIT_ZERO;
      end else begin
         rdData_ff  <= nxt_rdData;
         rdValid_ff <= nxt_rdValid;
      end
   end

   // the field view trails the select by one cycle, like every registered output
   always_comb begin
      nxt_field = '0;
      if (selOk) begin
         nxt_field = stWord;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst || coldRst) begin
         field_ff <= '0;
      end else begin
         field_ff <= nxt_field;
      end
   end

   assign rdData   = rdData_ff;
   assign rdValid  = rdValid_ff;
   assign fieldVal = field_ff;
   assign wrPulse  = cellPulse[ATTR_WRITE_ONLY];
endmodule : rac_attr_bank

/* File: testbench/rac_attr_bank_checker.sv */
// property checker for the register attribute bank
`timescale 1ns/1ps
module rac_attr_bank_checker
   import rac_pkg::*;
#(
   parameter int WIDTH = RAC_DEF_WIDTH
) (
   input wire logic             mclk,
   input wire logic             sys_rst,
   input wire logic             coldRst,
   input wire logic             rdEn,
   input wire logic             wrEn,
   input wire logic [3:0]       attrSel,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [WIDTH-1:0] hwSet,
   input wire logic [WIDTH-1:0] hwClr,
   input wire logic [WIDTH-1:0] hwVal,
   input wire logic [WIDTH-1:0] rdData,
   input wire logic             rdValid,
   input wire logic [WIDTH-1:0] fieldVal,
   input wire logic [WIDTH-1:0] wrPulse
);
   // =====================================================================
   // properties
   // =====================================================================
   wire logic rstAny = sys_rst | coldRst;
   default clocking @(posedge mclk); endclocking
   default disable iff (rstAny);
   a_read_answer: assert property (rdEn |=> rdValid)
      else $error("read not answered");
   a_valid_cause: assert property (rdValid |-> $past(rdEn))
      else $error("stray read valid");
   // word 0 lags its input by a cycle, so only a steady input is compared
   a_ro_value: assert property (
      rdEn && attrSel == 4'h0 && $stable(hwVal) && !$past(rstAny)
      |=> rdData == $past(hwVal)) else $error("read-only word wrong");
   a_wo_zero: assert property (rdEn && attrSel == 4'ha |=> rdData == '0)
      else $error("write-only word read nonzero");
   a_wo_pulse: assert property (
      1'b1 |=> wrPulse == ($past(wrEn && attrSel == 4'ha) ? $past(wrData) : '0))
      else $error("side effect pulse wrong");
   a_read_sets: assert property (
      rdEn && !wrEn && attrSel == 4'h2 ##1 attrSel == 4'h2 |=> fieldVal == '1)
      else $error("read did not set bits");
   a_rw_back: assert property (
      wrEn && attrSel == 4'h1 ##1 !wrEn ##1 rdEn && attrSel == 4'h1
      |=> rdData == $past(wrData, 3)) else $error("read-write readback");
   a_set_wins: assert property (
      attrSel == 4'h3 ##1 attrSel == 4'h3
      |=> (fieldVal & $past(hwSet, 2)) == $past(hwSet, 2)) else $error("event lost");
   c_read_set: cover property (rdEn && attrSel == 4'h2);
   c_lock: cover property (wrEn && attrSel == 4'h6 && wrData[WIDTH-1]);
   c_pulse: cover property (|wrPulse);
endmodule : rac_attr_bank_checker

bind rac_attr_bank rac_attr_bank_checker #(.WIDTH(WIDTH)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
   .coldRst(coldRst), .rdEn(rdEn), .wrEn(wrEn), .attrSel(attrSel), .wrData(wrData),
   .hwSet(hwSet), .hwClr(hwClr), .hwVal(hwVal), .rdData(rdData), .rdValid(rdValid),
   .fieldVal(fieldVal), .wrPulse(wrPulse));

/* File: testbench/rac_sw_host.sv */
// software-side model issuing reads and writes to the bank
`timescale 1ns/1ps
module rac_sw_host #(
   parameter int W = 8
) (
   input  wire logic  mclk,
   output logic       rdEn,
   output logic       wrEn,
   output logic [3:0] attrSel,
   output logic [W-1:0] wrData
);
   // =====================================================================
   // bus cycles
   // =====================================================================
   initial begin
      rdEn = 1'h0;
      wrEn = 1'h0;
      attrSel = 4'h0;
      wrData = '0;
   end
   // called just after an edge; the idle edge at the end keeps strobes single-assigned
   task automatic wr(input logic [3:0] a, input logic [W-1:0] d);
      wrEn <= 1'h1;
      attrSel <= a;
      wrData <= d;
      @(posedge mclk);
      wrEn <= 1'h0;
      @(posedge mclk);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      rdEn <= 1'h1;
      attrSel <= a;
      @(posedge mclk);
      rdEn <= 1'h0;
      @(posedge mclk);
   endtask : rd
endmodule : rac_sw_host

/* File: testbench/rac_attr_bank_bench.sv */
// self-checking bench for the register attribute bank
`timescale 1ns/1ps
module rac_attr_bank_bench;
   // =====================================================================
   // stimulus and wiring
   // =====================================================================
   logic       mclk = 1'h0;
   logic       sys_rst = 1'h1;
   logic       coldRst = 1'h1;
   logic [7:0] hwSet = 8'h00;
   logic [7:0] hwClr = 8'h00;
   logic [7:0] hwVal = 8'h5a;
   wire logic  rdEn, wrEn, rdValid;
   wire logic [3:0] attrSel;
   wire logic [7:0] wrData, rdData, fieldVal, wrPulse;
   int         num_errors = 0;
   int         compares = 0;
   int         cycles = 0;
   always #10 mclk = ~mclk;
   rac_sw_host #(.W(8)) host (.mclk(mclk), .rdEn(rdEn), .wrEn(wrEn), .attrSel(attrSel),
      .wrData(wrData));
   rac_attr_bank #(.WIDTH(8)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .coldRst(coldRst),
      .rdEn(rdEn), .wrEn(wrEn), .attrSel(attrSel), .wrData(wrData), .hwSet(hwSet),
      .hwClr(hwClr), .hwVal(hwVal), .rdData(rdData), .rdValid(rdValid),
      .fieldVal(fieldVal), .wrPulse(wrPulse));
   // =====================================================================
   // helpers
   // =====================================================================
   task automatic give_verdict();
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      host.rd(a);
      chk(rdData, exp);
   endtask : rd
   task automatic pulse(input logic cold);
      if (cold) coldRst <= 1'h1;
      else sys_rst <= 1'h1;
      @(posedge mclk);
      coldRst <= 1'h0;
      sys_rst <= 1'h0;
      @(posedge mclk);
   endtask : pulse
   always @(posedge mclk) begin
      cycles++;
      // ceiling well above the roughly 90 cycles the scenarios take
      if (cycles == 2000) begin
         num_errors++;
         give_verdict();
      end
   end
   // =====================================================================
   // scenarios
   // =====================================================================
   task automatic t_plain();
      rd(4'h1, 8'h00);
      host.wr(4'h0, 8'hff);
      rd(4'h0, 8'h5a);
      hwVal <= 8'ha3;
      @(posedge mclk);
      rd(4'h0, 8'ha3);
      host.wr(4'h1, 8'h3c);
      rd(4'h1, 8'h3c);
      chk(fieldVal, 8'h3c);
      rd(4'h2, 8'h00);
      rd(4'h2, 8'hff);
      host.wr(4'h2, 8'h0f);
      rd(4'h2, 8'hf0);
   endtask : t_plain
   task automatic t_event();
      hwSet <= 8'h81;
      @(posedge mclk);
      hwSet <= 8'h00;
      host.wr(4'h3, 8'h00);
      rd(4'h3, 8'h81);
      host.wr(4'h3, 8'h01);
      rd(4'h3, 8'h80);
      hwSet <= 8'h80;
      fork
         host.wr(4'h3, 8'h80);
         begin
            @(posedge mclk);
            hwSet <= 8'h00;
         end
      join
      rd(4'h3, 8'h80);
   endtask : t_event
   task automatic t_sticky();
      host.wr(4'h5, 8'h11);
      hwSet <= 8'h02;
      @(posedge mclk);
      hwSet <= 8'h00;
      pulse(1'h0);
      rd(4'h5, 8'h11);
      rd(4'h4, 8'h83);
      rd(4'h1, 8'h00);
      pulse(1'h1);
      rd(4'h5, 8'h00);
      rd(4'h4, 8'h00);
   endtask : t_sticky
   task automatic t_lock();
      host.wr(4'h6, 8'h81);
      host.wr(4'h6, 8'h07);
      rd(4'h6, 8'h81);
      host.wr(4'h8, 8'h01);
      rd(4'h8, 8'h00);
      pulse(1'h0);
      host.wr(4'h8, 8'h03);
      host.wr(4'h7, 8'h0c);
      hwClr <= 8'h05;
      @(posedge mclk);
      hwClr <= 8'h00;
      rd(4'h8, 8'h02);
      rd(4'h7, 8'h08);
   endtask : t_lock
   task automatic t_once();
      host.wr(4'h9, 8'h05);
      host.wr(4'h9, 8'h0a);
      rd(4'h9, 8'h05);
      pulse(1'h0);
      rd(4'h9, 8'h00);
      fork
         host.wr(4'ha, 8'ha5);
         begin
            @(posedge mclk);
            #1 chk(wrPulse, 8'ha5);
         end
      join
      rd(4'ha, 8'h00);
   endtask : t_once
   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'h0;
      coldRst <= 1'h0;
      @(posedge mclk);
      t_plain();
      t_event();
      t_sticky();
      t_lock();
      t_once();
      give_verdict();
   end
endmodule : rac_attr_bank_bench
